// file: flash_host_model.sv
// Purpose: behavioural serial host that issues whole frames to the flash command engine
// Assumes: serial clock idles low and runs only inside frames, 15 ns period
// Notes: lanes the host is not driving toggle, so stale levels never pass for data
`timescale 1ns/1ps
// ==========================================
// host model
module flash_host_model (
	output logic sck, // serial clock to the device
	output logic sel_n, // chip select, active low
	output logic [3:0] drv, // host lane levels
	input wire logic [3:0] lv, // resolved lane levels
	input wire logic [3:0] dev_oe // device lane enables
);
	logic [7:0] wq[$]; // bytes sent after the address
	logic [7:0] rq[$]; // bytes received
	logic saw_oe; // device drove a lane in this frame
	initial begin
		sck = 1'b0;
		sel_n = 1'b1;
		drv = 4'h0;
		saw_oe = 1'b0;
	end
	// change after the falling edge, device samples rising
	task automatic shift(input logic [3:0] v, input logic rd, output logic [3:0] s);
		drv = rd ? ~drv : v; // released lanes toggle every cycle
		#7.5;
		s = lv;
		saw_oe = saw_oe | (|dev_oe);
		sck = 1'b1;
		#7.5;
		sck = 1'b0;
	endtask : shift
	// select low from opcode to last bit
	task automatic frame(input logic [7:0] op, input int ab, input logic [31:0] a, input int w, input int dum,
		input int nrd);
		logic [3:0] s;
		logic [7:0] b;
		logic [3:0] m;
		rq.delete();
		saw_oe = 1'b0;
		m = (w == 4) ? 4'hf : (w == 2) ? 4'h3 : 4'h1;
		b = 8'h00;
		sel_n = 1'b0;
		#11;
		for (int i = 7; i >= 0; i--) shift({3'h0, op[i]}, 1'b0, s);
		for (int i = ab - w; i >= 0; i -= w) shift(4'(a >> i) & m, 1'b0, s);
		repeat (dum) shift(4'h0, 1'b1, s);
		foreach (wq[j]) for (int i = 8 - w; i >= 0; i -= w) shift(4'(wq[j] >> i) & m, 1'b0, s);
		repeat (nrd) begin
			for (int i = 0; i < 8; i += w) begin
				shift(4'h0, 1'b1, s);
				b = 8'((b << w) | ((w == 1) ? {3'h0, s[1]} : s & m)); // single lane answers on lane 1
			end
			rq.push_back(b);
		end
		sel_n = 1'b1;
		drv = ~drv;
		#201; // select stays high well over 160 ns
	endtask : frame
endmodule : flash_host_model

// file: flash_io_cfg.svh
// Purpose: constants of the serial flash command engine
// Assumes: included by the engine and the bench
// Notes: command codes are arbitrary; host and device must share them
`ifndef FLASH_IO_CFG_SVH
`define FLASH_IO_CFG_SVH
// ==========================================
// command codes
`define OP_WREN 8'h11
`define OP_WRDI 8'h12
`define OP_RDSR 8'h13
`define OP_RDID 8'h14
`define OP_FREAD 8'h21
`define OP_DREAD 8'h22
`define OP_QREAD 8'h24
`define OP_PROG 8'h31
`define OP_DPROG 8'h32
`define OP_QPROG 8'h34
`define OP_BULK 8'h41
`define OP_SECT 8'h42
`define OP_EN4B 8'h51
`define OP_EX4B 8'h52
// ==========================================
// array geometry and framing counts
`define ARRAY_BYTES 1024
`define ARRAY_AW 10
`define PAGE_BYTES 256
`define SECTOR_BIT 9
`define DUMMY_CYCLES 6'h08
`define ADDR_BITS_3B 6'h18
`define ADDR_BITS_4B 6'h20
`define ERASED_BYTE 8'hFF
`define DEVICE_ID 8'h5A // arbitrary value, names no real part
// ==========================================
// self-timed cycle times and clock rate
`define MCLK_MHZ 25
`define T_PROG_US 600
`define T_SECT_US 700000
`define T_BULK_US 30000000
`endif

// file: flash_io_engine.sv
// Purpose: serial flash command engine: reads, id, page program, erases, power mode
// Assumes: host samples on rising serial clock, device changes on falling edge
// Notes: array is a small flip-flop model; cycle times are parameters
// Summary of operation
// RL1: dual read moves address, data on two lanes
// RL2: quad read moves address, data on four lanes
// RL3: four-byte mode uses 32-bit addresses
// RL4: id byte leaves on lane 1, falling edge
// RL5: id read ignored while cycle runs
// RL6: host sets write enable before programming
// RL7: program completion clears write enable latch
// RL8: host sends opcode, address, data on lane 0
// RL9: page overrun wraps to page start
// RL10: host keeps select low whole program command
// RL11: over 256 bytes keeps last 256
// RL12: short program leaves other bytes unchanged
// RL13: program cycle starts at deselect
// RL14: write-in-progress reads 1 during cycle
// RL15: host erases first and waits each cycle
// RL16: dual program takes lanes 0 and 1
// RL17: quad program takes lanes 0 to 3
// RL18: bulk erase sets whole array to ones
// RL19: host sends bulk opcode only then deselects
// RL20: bulk erase clears write enable latch
// RL21: sector erase with any inner address
// RL22: active while selected or busy, else standby
// RL23: sample on rising, drive on falling edge
// RL24: host and device share command encodings
`timescale 1ns/1ps
`include "flash_io_cfg.svh"
module flash_io_engine #(
	parameter int PROG_CYCLES = `T_PROG_US * `MCLK_MHZ, // page program time in mclk cycles
	parameter int SECT_CYCLES = `T_SECT_US * `MCLK_MHZ, // sector erase time in mclk cycles
	parameter int BULK_CYCLES = `T_BULK_US * `MCLK_MHZ, // bulk erase time in mclk cycles
	parameter logic [7:0] DEVICE_ID = `DEVICE_ID // arbitrary identification value
) (
	input wire logic mclk, // system clock, 25 MHz
	input wire logic resetn, // asynchronous reset, active low
	input wire logic serial_shift_clock, // link clock from host
	input wire logic select_low, // chip select, active low
	input wire logic io_lane_0_in, // lane 0 level
	output logic io_lane_0_out, // lane 0 drive value
	output logic io_lane_0_oe, // lane 0 enable
	input wire logic io_lane_1_in, // lane 1 level
	output logic io_lane_1_out, // lane 1 drive value
	output logic io_lane_1_oe, // lane 1 enable
	input wire logic io_lane_2_in, // lane 2 level
	output logic io_lane_2_out, // lane 2 drive value
	output logic io_lane_2_oe, // lane 2 enable
	input wire logic io_lane_3_in, // lane 3 level
	output logic io_lane_3_out, // lane 3 drive value
	output logic io_lane_3_oe, // lane 3 enable
	output logic write_in_progress, // self-timed cycle running
	output logic write_enable_latch, // write enable latch state
	output logic four_byte_mode, // 32-bit addressing active
	output logic power_active // active power mode, low is standby
);
	// ==========================================
	// shared storage
	logic [7:0] mem_reg [`ARRAY_BYTES]; // flash array, mclk domain
	logic [7:0] buf_reg [`PAGE_BYTES]; // page buffer, link domain
	logic [`PAGE_BYTES-1:0] mask_reg; // bytes received this command
	logic [31:0] arm_addr_reg; // address of armed operation
	flash_io_pkg::arm_type arm_reg; // operation awaiting deselect
	logic four_byte_reg; // addressing mode
	// ==========================================
	// link domain frame state
	logic frame_rst_n; // frame ends whenever select goes high
	flash_io_pkg::link_state_type st_reg;
	flash_io_pkg::out_src_type src_reg;
	logic [5:0] cnt_reg; // bit or cycle count in phase
	logic [31:0] sh_reg; // input shift register
	logic [1:0] lanes_reg; // 0 one lane, 1 two, 2 four
	logic dummy_reg; // read needs dummy cycles
	logic prog_reg; // address belongs to a program
	logic [31:0] addr_reg; // current address
	logic [7:0] wr_idx_reg; // page buffer write index
	logic [3:0] din;
	logic [5:0] step;
	logic [31:0] sh_next;
	logic [7:0] opcode;
	logic byte_done;
	logic wip_l1_reg, wip_l2_reg, wel_l1_reg, wel_l2_reg; // status into link domain
	flash_io_pkg::lane_bus_type lanes_out_reg;

	assign frame_rst_n = resetn & ~select_low;
	assign din = {io_lane_3_in, io_lane_2_in, io_lane_1_in, io_lane_0_in};
	assign step = 6'h01 << lanes_reg;
	assign opcode = {sh_reg[6:0], din[0]};
	assign byte_done = (st_reg == flash_io_pkg::ST_DIN) && (cnt_reg + step == 6'h08);

	// ==========================================
	// input shift: lane 0 alone or lanes grouped, highest lane first
	always_comb begin
		case (lanes_reg)
			// RL1: two lane shift
			2'b01: sh_next = {sh_reg[29:0], din[1:0]};
			// RL2: four lane shift
			2'b10: sh_next = {sh_reg[27:0], din[3:0]};
			default: sh_next = {sh_reg[30:0], din[0]};
		endcase
	end

	// status copied into link domain; it refreshes only while the host clocks
	always_ff @(posedge serial_shift_clock or negedge resetn) begin
		if (!resetn) begin
			wip_l1_reg <= 1'b0;
			wip_l2_reg <= 1'b0;
			wel_l1_reg <= 1'b0;
			wel_l2_reg <= 1'b0;
		end else begin
			wip_l1_reg <= write_in_progress;
			wip_l2_reg <= wip_l1_reg;
			wel_l1_reg <= write_enable_latch;
			wel_l2_reg <= wel_l1_reg;
		end
	end

	// ==========================================
	// command sequencer, rising edge of the link clock
	// RL23: all host bits sampled on rising edge
	always_ff @(posedge serial_shift_clock or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			st_reg <= flash_io_pkg::ST_OPCODE;
			src_reg <= flash_io_pkg::SRC_STATUS;
			cnt_reg <= 6'h00;
			sh_reg <= 32'h0000_0000;
			lanes_reg <= 2'b00;
			dummy_reg <= 1'b0;
			prog_reg <= 1'b0;
			addr_reg <= 32'h0000_0000;
			wr_idx_reg <= 8'h00;
		end else begin
			sh_reg <= sh_next;
			cnt_reg <= cnt_reg + step;
			case (st_reg)
				flash_io_pkg::ST_OPCODE: begin
					if (cnt_reg == 6'h07) begin
						cnt_reg <= 6'h00;
						st_reg <= flash_io_pkg::ST_IGNORE;
						// RL24: shared command encodings
						case (opcode)
							`OP_RDSR: begin
								st_reg <= flash_io_pkg::ST_DOUT;
								src_reg <= flash_io_pkg::SRC_STATUS;
							end
							`OP_RDID: begin
								// RL5: identifier read dropped while busy
								if (!wip_l2_reg) begin
									st_reg <= flash_io_pkg::ST_DOUT;
									src_reg <= flash_io_pkg::SRC_ID;
								end
							end
							`OP_FREAD, `OP_DREAD, `OP_QREAD: begin
								if (!wip_l2_reg) begin
									st_reg <= flash_io_pkg::ST_ADDR;
									src_reg <= flash_io_pkg::SRC_ARRAY;
									dummy_reg <= 1'b1;
									// RL1: dual read lanes
									// RL2: quad read lanes
									lanes_reg <= (opcode == `OP_QREAD) ? 2'b10 : ((opcode == `OP_DREAD) ? 2'b01 : 2'b00);
								end
							end
							`OP_PROG, `OP_DPROG, `OP_QPROG: begin
								if (!wip_l2_reg) begin
									st_reg <= flash_io_pkg::ST_ADDR;
									prog_reg <= 1'b1;
									// RL16: dual program lanes
									// RL17: quad program lanes
									lanes_reg <= (opcode == `OP_QPROG) ? 2'b10 : ((opcode == `OP_DPROG) ? 2'b01 : 2'b00);
								end
							end
							`OP_SECT: begin
								if (!wip_l2_reg) begin
									st_reg <= flash_io_pkg::ST_ADDR;
								end
							end
							default: begin
								st_reg <= flash_io_pkg::ST_IGNORE;
							end
						endcase
					end
				end
				flash_io_pkg::ST_ADDR: begin
					// RL3: address length follows addressing mode
					if (cnt_reg + step == (four_byte_reg ? `ADDR_BITS_4B : `ADDR_BITS_3B)) begin
						cnt_reg <= 6'h00;
						addr_reg <= four_byte_reg ? sh_next : {8'h00, sh_next[23:0]};
						// RL9: buffer index starts at address low byte
						wr_idx_reg <= sh_next[7:0];
						if (prog_reg) begin
							st_reg <= flash_io_pkg::ST_DIN;
						end else if (dummy_reg) begin
							st_reg <= flash_io_pkg::ST_DUMMY;
						end else begin
							st_reg <= flash_io_pkg::ST_IGNORE;
						end
					end
				end
				flash_io_pkg::ST_DUMMY: begin
					cnt_reg <= cnt_reg + 6'h01;
					if (cnt_reg == `DUMMY_CYCLES - 6'h01) begin
						cnt_reg <= 6'h00;
						st_reg <= flash_io_pkg::ST_DOUT;
					end
				end
				flash_io_pkg::ST_DIN: begin
					if (byte_done) begin
						cnt_reg <= 6'h00;
						// RL9: index wraps inside the page
						wr_idx_reg <= wr_idx_reg + 8'h01;
					end
				end
				flash_io_pkg::ST_DOUT: begin
					if (cnt_reg + step == 6'h08) begin
						cnt_reg <= 6'h00;
						addr_reg <= addr_reg + 32'h0000_0001;
					end
				end
				default: begin
					cnt_reg <= 6'h00;
				end
			endcase
		end
	end

	// ==========================================
	// persistent link state: mode, armed operation, page buffer
	always_ff @(posedge serial_shift_clock or negedge resetn) begin
		if (!resetn) begin
			four_byte_reg <= 1'b0;
			arm_reg <= flash_io_pkg::ARM_NONE;
			arm_addr_reg <= 32'h0000_0000;
			mask_reg <= '0;
			for (int i = 0; i < `PAGE_BYTES; i++) begin
				buf_reg[i] <= 8'h00;
			end
		end else begin
			if (st_reg == flash_io_pkg::ST_OPCODE && cnt_reg == 6'h00) begin
				arm_reg <= flash_io_pkg::ARM_NONE;
			end
			if (st_reg == flash_io_pkg::ST_OPCODE && cnt_reg == 6'h07) begin
				case (opcode)
					`OP_WREN: arm_reg <= flash_io_pkg::ARM_WREN;
					`OP_WRDI: arm_reg <= flash_io_pkg::ARM_WRDI;
					`OP_EN4B: four_byte_reg <= 1'b1;
					`OP_EX4B: four_byte_reg <= 1'b0;
					`OP_BULK: arm_reg <= wip_l2_reg ? flash_io_pkg::ARM_NONE : flash_io_pkg::ARM_BULK;
					// a refused program must not disturb the mask of the one in flight
					`OP_PROG, `OP_DPROG, `OP_QPROG: mask_reg <= wip_l2_reg ? mask_reg : '0;
					default: arm_reg <= flash_io_pkg::ARM_NONE;
				endcase
			end
			if (st_reg == flash_io_pkg::ST_ADDR && !dummy_reg &&
					cnt_reg + step == (four_byte_reg ? `ADDR_BITS_4B : `ADDR_BITS_3B)) begin
				// RL21: sector chosen by any address inside it
				arm_reg <= prog_reg ? flash_io_pkg::ARM_PROG : flash_io_pkg::ARM_SECT;
				arm_addr_reg <= four_byte_reg ? sh_next : {8'h00, sh_next[23:0]};
			end
			// RL11: later bytes overwrite earlier ones in the page
			if (byte_done) begin
				buf_reg[wr_idx_reg] <= sh_next[7:0];
				mask_reg[wr_idx_reg] <= 1'b1;
			end
		end
	end

	// ==========================================
	// output drivers, falling edge of the link clock
	// enables drop at once when select goes high
	always_ff @(negedge serial_shift_clock or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			lanes_out_reg <= '0;
		end else if (st_reg == flash_io_pkg::ST_DOUT) begin
			// RL23: output changes on the falling edge
			case (lanes_reg)
				2'b01: begin
					lanes_out_reg.dout <= out_shift(8'd7 - 8'(cnt_reg), 2'b01);
					lanes_out_reg.oe <= 4'b0011;
				end
				2'b10: begin
					lanes_out_reg.dout <= out_shift(8'd7 - 8'(cnt_reg), 2'b10);
					lanes_out_reg.oe <= 4'b1111;
				end
				default: begin
					// RL4: single lane data, identifier included, on lane 1
					lanes_out_reg.dout <= out_shift(8'd7 - 8'(cnt_reg), 2'b00);
					lanes_out_reg.oe <= 4'b0010;
				end
			endcase
		end else begin
			lanes_out_reg <= '0;
		end
	end

	// picks the next group of bits of the outgoing byte, highest first
	function automatic logic [3:0] out_shift(input logic [7:0] top, input logic [1:0] lanes);
		logic [7:0] b;
		b = (src_reg == flash_io_pkg::SRC_ARRAY) ? mem_reg[addr_reg[`ARRAY_AW-1:0]] :
			((src_reg == flash_io_pkg::SRC_ID) ? DEVICE_ID : {6'h00, wel_l2_reg, wip_l2_reg});
		case (lanes)
			2'b01: out_shift = {2'b00, b[top[2:0]], b[top[2:0] - 3'd1]};
			2'b10: out_shift = top[2] ? b[7:4] : b[3:0];
			default: out_shift = {2'b00, b[top[2:0]], 1'b0}; // single lane answers on lane 1
		endcase
	endfunction : out_shift

	assign {io_lane_3_out, io_lane_2_out, io_lane_1_out, io_lane_0_out} = lanes_out_reg.dout;
	assign {io_lane_3_oe, io_lane_2_oe, io_lane_1_oe, io_lane_0_oe} = lanes_out_reg.oe;
	assign four_byte_mode = four_byte_reg;

	// ==========================================
	// system clock domain: deselect detection and self-timed cycles
	logic cs_s1_reg, cs_s2_reg, cs_s3_reg; // select synchroniser and edge stage
	flash_io_pkg::arm_type arm_s1_reg, arm_s2_reg; // armed operation, stable across deselect
	flash_io_pkg::arm_type kind_reg; // operation in flight
	logic busy_reg; // self-timed cycle running
	logic wel_reg; // write enable latch
	logic active_reg; // power mode
	logic [31:0] timer_reg; // cycles left in the cycle
	logic deselect;
	logic finish;

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			cs_s1_reg <= 1'b1;
			cs_s2_reg <= 1'b1;
			cs_s3_reg <= 1'b1;
			arm_s1_reg <= flash_io_pkg::ARM_NONE;
			arm_s2_reg <= flash_io_pkg::ARM_NONE;
		end else begin
			cs_s1_reg <= select_low;
			cs_s2_reg <= cs_s1_reg;
			cs_s3_reg <= cs_s2_reg;
			arm_s1_reg <= arm_reg;
			arm_s2_reg <= arm_s1_reg;
		end
	end
	assign deselect = cs_s2_reg & ~cs_s3_reg;
	assign finish = busy_reg && (timer_reg == 32'h0000_0000);

	// cycle timer; commands are only honoured while idle
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			busy_reg <= 1'b0;
			timer_reg <= 32'h0000_0000;
			kind_reg <= flash_io_pkg::ARM_NONE;
		end else if (busy_reg) begin
			timer_reg <= timer_reg - 32'h0000_0001;
			// RL14: busy ends when the timer runs out
			if (finish) begin
				busy_reg <= 1'b0;
			end
		// RL13: cycle begins on deselect
		// RL6: program or erase only with latch set
		end else if (deselect && wel_reg) begin
			kind_reg <= arm_s2_reg;
			case (arm_s2_reg)
				flash_io_pkg::ARM_PROG: begin
					busy_reg <= 1'b1;
					timer_reg <= 32'(PROG_CYCLES - 1);
				end
				flash_io_pkg::ARM_SECT: begin
					busy_reg <= 1'b1;
					timer_reg <= 32'(SECT_CYCLES - 1);
				end
				flash_io_pkg::ARM_BULK: begin
					busy_reg <= 1'b1;
					timer_reg <= 32'(BULK_CYCLES - 1);
				end
				default: begin
					busy_reg <= 1'b0;
				end
			endcase
		end
	end

	// write enable latch
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			wel_reg <= 1'b0;
		// RL7: cleared when the program completes
		end else if (finish) begin
			wel_reg <= 1'b0;
		// RL20: erases clear it at their start
		end else if (busy_reg && kind_reg != flash_io_pkg::ARM_PROG) begin
			wel_reg <= 1'b0;
		end else if (deselect && !busy_reg && arm_s2_reg == flash_io_pkg::ARM_WREN) begin
			wel_reg <= 1'b1;
		end else if (deselect && !busy_reg && arm_s2_reg == flash_io_pkg::ARM_WRDI) begin
			wel_reg <= 1'b0;
		end
	end

	// array update in the last cycle of the timed operation
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			for (int i = 0; i < `ARRAY_BYTES; i++) begin
				mem_reg[i] <= `ERASED_BYTE;
			end
		end else if (finish) begin
			for (int i = 0; i < `ARRAY_BYTES; i++) begin
				// RL12: only received bytes of the page change
				if (kind_reg == flash_io_pkg::ARM_PROG && i[9:8] == arm_addr_reg[9:8] && mask_reg[i[7:0]]) begin
					mem_reg[i] <= mem_reg[i] & buf_reg[i[7:0]];
				end
				// RL21: whole sector set to ones
				if (kind_reg == flash_io_pkg::ARM_SECT && i[`SECTOR_BIT] == arm_addr_reg[`SECTOR_BIT]) begin
					mem_reg[i] <= `ERASED_BYTE;
				end
				// RL18: bulk erase sets every byte to ones
				if (kind_reg == flash_io_pkg::ARM_BULK) begin
					mem_reg[i] <= `ERASED_BYTE;
				end
			end
		end
	end

	// RL22: active while selected or a cycle runs
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			active_reg <= 1'b0;
		end else begin
			active_reg <= ~cs_s2_reg | busy_reg;
		end
	end
	assign write_in_progress = busy_reg;
	assign write_enable_latch = wel_reg;
	assign power_active = active_reg;

	// ==========================================
	// checks
	a_wip_tracks_timer: assert property (@(posedge mclk) disable iff (!resetn) // RL14
		(busy_reg && timer_reg != 32'h0000_0000) |=> write_in_progress) else $error("wip dropped early");
	a_wel_after_cycle: assert property (@(posedge mclk) disable iff (!resetn) // RL7
		$fell(busy_reg) |-> !wel_reg) else $error("latch still set after cycle");
	a_start_on_deselect: assert property (@(posedge mclk) disable iff (!resetn) // RL13
		(deselect && !busy_reg && wel_reg && arm_s2_reg == flash_io_pkg::ARM_PROG) |=> busy_reg)
		else $error("program did not start");
	a_start_needs_wel: assert property (@(posedge mclk) disable iff (!resetn) // RL6
		$rose(busy_reg) |-> $past(wel_reg)) else $error("cycle without latch");
	a_bulk_fills_ones: assert property (@(posedge mclk) disable iff (!resetn) // RL18
		(finish && kind_reg == flash_io_pkg::ARM_BULK) |=> (mem_reg[0] == `ERASED_BYTE && mem_reg[`ARRAY_BYTES-1] == `ERASED_BYTE))
		else $error("bulk erase left zeros");
	a_erase_clears_wel: assert property (@(posedge mclk) disable iff (!resetn) // RL20
		($rose(busy_reg) && kind_reg == flash_io_pkg::ARM_BULK) |=> !wel_reg) else $error("erase kept latch");
	a_standby_entry: assert property (@(posedge mclk) disable iff (!resetn) // RL22
		(cs_s2_reg && !busy_reg) |=> !power_active) else $error("no standby");
	a_id_ignored_busy: assert property (@(posedge serial_shift_clock) disable iff (!frame_rst_n) // RL5
		(st_reg == flash_io_pkg::ST_OPCODE && cnt_reg == 6'h07 && opcode == `OP_RDID && wip_l2_reg)
		|=> st_reg == flash_io_pkg::ST_IGNORE) else $error("id read while busy");
	a_addr_length: assert property (@(posedge serial_shift_clock) disable iff (!frame_rst_n) // RL3
		(st_reg == flash_io_pkg::ST_ADDR && four_byte_reg && cnt_reg + step == `ADDR_BITS_4B)
		|=> st_reg != flash_io_pkg::ST_ADDR) else $error("address overran 32 bits");
	a_page_wrap: assert property (@(posedge serial_shift_clock) disable iff (!frame_rst_n) // RL9
		(byte_done && wr_idx_reg == 8'hFF) |=> wr_idx_reg == 8'h00) else $error("page did not wrap");
endmodule : flash_io_engine

// file: flash_io_pkg.sv
// Purpose: types shared by the serial flash command engine
// Assumes: nothing beyond the cfg header
// Notes: codes written out for stable state dumps
package flash_io_pkg;
	// ==========================================
	// link side command phases
	typedef enum logic [2:0] {
		ST_OPCODE = 3'b000, // collecting the command byte
		ST_ADDR = 3'b001, // collecting the address
		ST_DUMMY = 3'b010, // idle cycles before read data
		ST_DIN = 3'b011, // program data coming in
		ST_DOUT = 3'b100, // data going out
		ST_IGNORE = 3'b101 // frame swallowed until deselect
	} link_state_type;
	// operation handed to the clock domain at deselect
	typedef enum logic [2:0] {
		ARM_NONE = 3'b000,
		ARM_WREN = 3'b001,
		ARM_WRDI = 3'b010,
		ARM_PROG = 3'b011,
		ARM_SECT = 3'b100,
		ARM_BULK = 3'b101
	} arm_type;
	// source of outgoing bytes
	typedef enum logic [1:0] {
		SRC_STATUS = 2'b00,
		SRC_ID = 2'b01,
		SRC_ARRAY = 2'b10
	} out_src_type;
	// four lane output driver bundle
	typedef struct packed {
		logic [3:0] dout; // lane levels
		logic [3:0] oe; // lane enables, high drives
	} lane_bus_type;
endpackage : flash_io_pkg

// file: serial_flash_program_erase_io_tb_top.sv
// Purpose: self-checking bench for the serial flash command engine
// Assumes: short self-timed cycle counts so programs and erases finish fast
// Notes: flags are sampled on the falling mclk edge, away from their updates
`timescale 1ns/1ps
`include "flash_io_cfg.svh"
module serial_flash_program_erase_io_tb_top;
	logic mclk; // system clock
	logic resetn; // reset, active low
	logic sck; // serial clock
	logic sel_n; // select, active low
	logic [3:0] drv; // host lane levels
	logic [3:0] dout; // device lane levels
	logic [3:0] oe; // device lane enables
	logic [3:0] lv; // resolved lanes
	logic wip, wel, fbm, pwr; // device flags
	int error_cnt = 0; // mismatches
	int checks = 0; // comparisons
	int cyc = 0; // cycles run
	logic [7:0] eq[$]; // expected read bytes
	logic [7:0] pat[$] = '{8'ha5, 8'h3c, 8'h0f, 8'hc3}; // lane test pattern
	logic [7:0] wop[2] = '{`OP_DPROG, `OP_QPROG}; // wide programs
	logic [7:0] rop[2] = '{`OP_DREAD, `OP_QREAD}; // wide reads
	// the device owns a lane while it drives it
	assign lv = (oe & dout) | (~oe & drv);
	flash_io_engine #(.PROG_CYCLES(20), .SECT_CYCLES(30), .BULK_CYCLES(40),
		.DEVICE_ID(8'h3c)) flash_io_engine_inst ( // id value is arbitrary
		.mclk(mclk), .resetn(resetn), .serial_shift_clock(sck), .select_low(sel_n),
		.io_lane_0_in(lv[0]), .io_lane_0_out(dout[0]), .io_lane_0_oe(oe[0]),
		.io_lane_1_in(lv[1]), .io_lane_1_out(dout[1]), .io_lane_1_oe(oe[1]),
		.io_lane_2_in(lv[2]), .io_lane_2_out(dout[2]), .io_lane_2_oe(oe[2]),
		.io_lane_3_in(lv[3]), .io_lane_3_out(dout[3]), .io_lane_3_oe(oe[3]),
		.write_in_progress(wip), .write_enable_latch(wel), .four_byte_mode(fbm), .power_active(pwr));
	flash_host_model flash_host_model_inst (.sck(sck), .sel_n(sel_n), .drv(drv), .lv(lv), .dev_oe(oe));
	// ==========================================
	// clock and hang guard
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	// whole run needs some 1500 cycles, so this only trips on a hang
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			error_cnt++;
			summarize();
		end
	end
	// ==========================================
	// tasks
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : summarize
	task automatic check_byte(input string what, input logic [7:0] e, input logic [7:0] g);
		checks++;
		if (g !== e) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", what, e, g);
		end
	endtask : check_byte
	task automatic check_bit(input string what, input logic e, input logic g);
		checks++;
		if (g !== e) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %b seen %b", what, e, g);
		end
	endtask : check_bit
	task automatic fr(input logic [7:0] op, input int ab, input logic [31:0] a, input int w, input int dum, input int n);
		flash_host_model_inst.frame(op, ab, a, w, dum, n);
	endtask : fr
	task automatic put(input logic [7:0] b);
		flash_host_model_inst.wq.push_back(b);
	endtask : put
	// write enable goes first when en is set
	task automatic prog(input logic [7:0] op, input int w, input int ab, input logic [31:0] a, input logic en);
		if (en) fr(`OP_WREN, 0, 0, 1, 0, 0);
		fr(op, ab, a, w, 0, 0);
		flash_host_model_inst.wq.delete();
	endtask : prog
	task automatic one(input logic [7:0] op, input logic [7:0] e);
		fr(op, 0, 0, 1, 0, 1);
		check_byte("status or id byte", e, flash_host_model_inst.rq[0]);
	endtask : one
	task automatic rd_chk(input logic [7:0] op, input int w, input int ab, input logic [31:0] a);
		fr(op, ab, a, w, `DUMMY_CYCLES, eq.size());
		foreach (eq[i]) check_byte("read data", eq[i], flash_host_model_inst.rq[i]);
		eq.delete();
	endtask : rd_chk
	task automatic flags(input logic b, input logic e, input logic p);
		@(negedge mclk);
		check_bit("write in progress", b, wip);
		check_bit("write enable latch", e, wel);
		check_bit("power active", p, pwr);
	endtask : flags
	// wait out each self-timed cycle before the next write
	task automatic wait_idle();
		for (int i = 0; i < 200 && wip !== 1'b0; i++) @(negedge mclk);
		repeat (2) @(negedge mclk);
	endtask : wait_idle
	// ==========================================
	// test sequence
	initial begin
		resetn = 1'b0;
		repeat (20) @(posedge mclk);
		resetn <= 1'b1;
		repeat (4) @(posedge mclk);
		flags(1'b0, 1'b0, 1'b0);
		one(`OP_RDSR, 8'h00);
		one(`OP_RDID, 8'h3c);
		put(8'h00);
		prog(`OP_PROG, 1, 24, 32'h0000_0000, 1'b0);
		eq = '{8'hff};
		rd_chk(`OP_FREAD, 1, 24, 32'h0000_0000);
		for (int i = 0; i < 20; i++) put(8'(i + 1));
		prog(`OP_PROG, 1, 24, 32'h0000_00f0, 1'b1);
		flags(1'b1, 1'b1, 1'b1);
		one(`OP_RDSR, 8'h03);
		fr(`OP_RDID, 0, 0, 1, 0, 1);
		check_bit("id lane drive while busy", 1'b0, flash_host_model_inst.saw_oe);
		wait_idle();
		flags(1'b0, 1'b0, 1'b0);
		eq = '{8'h0f, 8'h10};
		rd_chk(`OP_FREAD, 1, 24, 32'h0000_00fe);
		eq = '{8'h11, 8'h12, 8'h13, 8'h14, 8'hff};
		rd_chk(`OP_FREAD, 1, 24, 32'h0000_0000);
		for (int i = 0; i < 258; i++) put(8'(i >> 1));
		prog(`OP_PROG, 1, 24, 32'h0000_0100, 1'b1);
		wait_idle();
		eq = '{8'h80, 8'h80, 8'h01, 8'h01};
		rd_chk(`OP_FREAD, 1, 24, 32'h0000_0100);
		for (int k = 0; k < 2; k++) begin
			foreach (pat[i]) put(pat[i]);
			prog(wop[k], 2 * (k + 1), 24, 32'(512 + 256 * k), 1'b1);
			wait_idle();
			eq = pat;
			rd_chk(rop[k], 2 * (k + 1), 24, 32'(512 + 256 * k));
		end
		fr(`OP_EN4B, 0, 0, 1, 0, 0);
		check_bit("four byte mode", 1'b1, fbm);
		eq = pat;
		rd_chk(`OP_QREAD, 4, 32, 32'h0000_0300);
		fr(`OP_EX4B, 0, 0, 1, 0, 0);
		check_bit("four byte mode", 1'b0, fbm);
		prog(`OP_SECT, 1, 24, 32'h0000_02ab, 1'b1);
		flags(1'b1, 1'b0, 1'b1);
		one(`OP_RDSR, 8'h01);
		wait_idle();
		eq = '{8'h7f, 8'hff};
		rd_chk(`OP_FREAD, 1, 24, 32'h0000_01ff);
		eq = '{8'hff};
		rd_chk(`OP_QREAD, 4, 24, 32'h0000_0300);
		prog(`OP_BULK, 1, 0, 32'h0000_0000, 1'b1);
		flags(1'b1, 1'b0, 1'b1);
		one(`OP_RDSR, 8'h01);
		wait_idle();
		eq = '{8'hff, 8'hff};
		rd_chk(`OP_DREAD, 2, 24, 32'h0000_00ff);
		fr(`OP_WREN, 0, 0, 1, 0, 0);
		flags(1'b0, 1'b1, 1'b0);
		fr(`OP_WRDI, 0, 0, 1, 0, 0);
		flags(1'b0, 1'b0, 1'b0);
		summarize();
	end
endmodule : serial_flash_program_erase_io_tb_top
